// File: common/smed_pkg.sv
// Shared constants, field layouts and carrier types of the serial module control block.
package smed_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register addresses on the plain register port.
  localparam logic [ADDR_W-1:0] ADDR_CTRL_FIRST  = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_SECOND = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS       = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT    = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_INT_EN      = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_INT_CLR     = 3'h5;

  // Field positions inside serial_ctrl_first.
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned MODE_W   = 3;
  localparam int unsigned RSVD_BIT = 4;
  localparam int unsigned DEB_LSB  = 2;
  localparam int unsigned DEB_W    = 2;
  localparam int unsigned EN_BIT   = 1;
  localparam int unsigned ICF_BIT  = 0;

  // Field positions inside the second control register.
  localparam int unsigned TXDIR_BIT = 0;
  localparam int unsigned TXACK_BIT = 1;

  // Reset values.
  localparam logic [MODE_W-1:0] MODE_RST   = 3'h7;
  localparam logic [DEB_W-1:0]  DEB_RST    = 2'h0;
  localparam logic              EN_RST     = 1'h0;
  localparam logic              ICF_RST    = 1'h0;
  localparam logic              TXDIR_RST  = 1'h0;
  localparam logic              TXACK_RST  = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

  // Operating mode codes.
  typedef enum logic [MODE_W-1:0] {
    SMED_MODE_SPI_M_DIV4  = 3'h0,
    SMED_MODE_SPI_M_DIV16 = 3'h1,
    SMED_MODE_SPI_M_DIV64 = 3'h2,
    SMED_MODE_SPI_M_SUB   = 3'h3,
    SMED_MODE_SPI_M_TMR   = 3'h4,
    SMED_MODE_SPI_SLAVE   = 3'h5,
    SMED_MODE_I2C_SLAVE   = 3'h6,
    SMED_MODE_NONE        = 3'h7
  } smed_mode_t;

  // Debounce select codes and their lengths in system clock cycles.
  localparam logic [DEB_W-1:0] DEB_CODE_NONE = 2'h0;
  localparam logic [DEB_W-1:0] DEB_CODE_TWO  = 2'h1;
  localparam int unsigned      DEB_CNT_W     = 3;
  localparam logic [DEB_CNT_W-1:0] DEB_NONE_CYC = 3'h0;
  localparam logic [DEB_CNT_W-1:0] DEB_TWO_CYC  = 3'h2;
  localparam logic [DEB_CNT_W-1:0] DEB_FOUR_CYC = 3'h4;

  // Idle level of the two-wire lines and the level an open-drain driver pulls to.
  localparam logic LINE_IDLE  = 1'h1;
  localparam logic DRIVE_LEVL = 1'h0;

  // Two-wire status flags.
  typedef struct packed {
    logic transfer_complete;
    logic address_match;
    logic bus_busy;
    logic slave_read_write;
    logic received_ack;
  } smed_flags_t;

  localparam smed_flags_t FLAGS_DEFAULT = 5'h00;

  // Interrupt sources, one sticky bit each.
  localparam int unsigned IRQ_W = 4;
  typedef struct packed {
    logic flags_defaulted;
    logic address_match;
    logic transfer_complete;
    logic spi_incomplete;
  } smed_irq_t;

endpackage : smed_pkg

// File: core/smed_sync2.sv
// Two-flop synchroniser for levels entering from outside the system clock domain.
module smed_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] rst_val_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage; reset loads rst_val_in into both.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta  <= rst_val_in;
      q_out <= rst_val_in;
    end else if (ce_in) begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : smed_sync2

// File: core/smed_debounce.sv
// Selectable debounce filter for the externally driven bus clock line.
module smed_debounce (
  input  wire logic                           core_clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           ce_in,
  input  wire logic                           run_in,
  input  wire logic [smed_pkg::DEB_W-1:0]     sel_in,
  input  wire logic                           d_in,
  output logic                                q_out
);
  import smed_pkg::*;

  logic [DEB_CNT_W-1:0] cnt;
  logic [DEB_CNT_W-1:0] target;
  logic [DEB_CNT_W-1:0] next_cnt;
  logic                 settled;

  // Code 00 passes straight through, 01 needs two stable cycles, 1x needs four.
  assign target   = (sel_in == DEB_CODE_NONE) ? DEB_NONE_CYC :
                    (sel_in == DEB_CODE_TWO)  ? DEB_TWO_CYC  : DEB_FOUR_CYC;
  assign next_cnt = DEB_CNT_W'(cnt + 1'b1);
  assign settled  = (next_cnt >= target);

  // A new level is taken only once it has differed from the output for target cycles.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q_out <= LINE_IDLE;
      cnt   <= DEB_NONE_CYC;
    end else if (ce_in) begin
      if (!run_in) begin
        q_out <= LINE_IDLE;
        cnt   <= DEB_NONE_CYC;
      end else if (d_in == q_out) begin
        cnt <= DEB_NONE_CYC;
      end else if (settled) begin
        q_out <= d_in;
        cnt   <= DEB_NONE_CYC;
      end else begin
        cnt <= next_cnt;
      end
    end
  end

endmodule : smed_debounce

// File: core/smed_ctrl.sv
// Enable, mode, debounce and flag control of the serial interface module.
//
// The address-and-strobe port and the register addresses were decided locally.
module smed_ctrl (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          ce_in,
  input  wire logic [smed_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [smed_pkg::DATA_W-1:0]   reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [smed_pkg::DATA_W-1:0]   reg_rdata_out,
  input  wire logic                          hw_option_enable_in,
  input  wire logic                          scl_pin_in,
  input  wire logic                          sda_pin_in,
  input  wire logic                          scl_hold_low_in,
  input  wire logic                          sda_drive_low_in,
  input  wire logic                          spi_incomplete_in,
  input  wire logic                          flags_load_in,
  input  smed_pkg::smed_flags_t              flags_next_in,
  output logic                               scl_out,
  output logic                               scl_oe_out,
  output logic                               sda_out,
  output logic                               sda_oe_out,
  output logic                               scl_filtered_out,
  output logic                               sda_sampled_out,
  output logic                               scl_rise_out,
  output logic                               scl_fall_out,
  output logic      [smed_pkg::MODE_W-1:0]   operating_mode_select_out,
  output logic                               i2c_active_out,
  output logic                               spi_active_out,
  output logic                               transmit_direction_ctl_out,
  output logic                               transmit_ack_ctl_out,
  output smed_pkg::smed_flags_t              flags_out,
  output logic                               irq_out
);
  import smed_pkg::*;

  // Software-visible control state.
  logic [MODE_W-1:0] operating_mode_select;
  logic [DEB_W-1:0]  debounce_select;
  logic              module_enable;
  logic              spi_incomplete_flag;
  logic              transmit_direction_ctl;
  logic              transmit_ack_ctl;
  smed_flags_t       flags;
  smed_irq_t         int_stat;
  smed_irq_t         int_en;

  // Internal history and synchronised pins.
  logic              enable_prev;
  logic              option_sync;
  logic              scl_sync;
  logic              sda_sync;
  logic              scl_deb;
  logic              scl_deb_prev;

  // Decoded strobes and derived levels.
  logic              wr_ctrl_first;
  logic              wr_ctrl_second;
  logic              wr_int_en;
  logic              wr_int_clr;
  logic              enable_eff;
  logic              enable_rise;
  logic              mode_is_i2c;
  logic              mode_is_none;
  logic              i2c_run;
  logic              spi_run;
  logic              flags_to_default;
  logic              flags_take_new;
  logic              icf_set;
  smed_flags_t       next_flags;
  smed_irq_t         irq_events;
  smed_irq_t         clr_mask;
  smed_irq_t         next_int_stat;
  logic              next_icf;
  logic [DATA_W-1:0] ctrl_first_rd;
  logic [DATA_W-1:0] ctrl_second_rd;
  logic [DATA_W-1:0] rd_mux;

  // Register write decode; strobes never overlap, so no priority is needed.
  assign wr_ctrl_first  = reg_wr_in && (reg_addr_in == ADDR_CTRL_FIRST);
  assign wr_ctrl_second = reg_wr_in && (reg_addr_in == ADDR_CTRL_SECOND);
  assign wr_int_en      = reg_wr_in && (reg_addr_in == ADDR_INT_EN);
  assign wr_int_clr     = reg_wr_in && (reg_addr_in == ADDR_INT_CLR);

  // Mode decode and the effective enable that the hardware option gates.
  assign mode_is_i2c  = (operating_mode_select == SMED_MODE_I2C_SLAVE);
  assign mode_is_none = (operating_mode_select == SMED_MODE_NONE);
  assign enable_eff   = module_enable && option_sync;
  assign i2c_run      = enable_eff && mode_is_i2c;
  assign spi_run      = enable_eff && !mode_is_i2c && !mode_is_none;
  assign enable_rise  = enable_eff && !enable_prev;

  // Flags default on an enable rise in two-wire mode; that beats a datapath load.
  assign flags_to_default = enable_rise && mode_is_i2c;
  assign flags_take_new   = flags_load_in && i2c_run;
  assign next_flags       = flags_to_default ? FLAGS_DEFAULT :
                            flags_take_new   ? flags_next_in : flags;

  // The incomplete flag is set by its input only while SPI runs, or by a software write of one; the input set beats a software clear.
  assign icf_set  = spi_incomplete_in && spi_run;
  assign next_icf = icf_set ? 1'b1 :
                    wr_ctrl_first ? reg_wdata_in[ICF_BIT] : spi_incomplete_flag;

  // Interrupt events in the system clock domain; the incomplete event lasts as long as its input, the others are one-cycle conditions.
  assign irq_events.spi_incomplete    = icf_set;
  assign irq_events.transfer_complete = flags_take_new && !flags_to_default &&
                                        flags_next_in.transfer_complete &&
                                        !flags.transfer_complete;
  assign irq_events.address_match     = flags_take_new && !flags_to_default &&
                                        flags_next_in.address_match &&
                                        !flags.address_match;
  assign irq_events.flags_defaulted   = flags_to_default;

  // Clearing writes ones; an event landing in the same cycle stays set.
  assign clr_mask      = wr_int_clr ? smed_irq_t'(reg_wdata_in[IRQ_W-1:0]) : '0;
  assign next_int_stat = (int_stat & ~clr_mask) | irq_events;

  // Read images; the unimplemented bit is always zero.
  always_comb begin
    ctrl_first_rd                            = '0;
    ctrl_first_rd[MODE_LSB +: MODE_W]        = operating_mode_select;
    ctrl_first_rd[RSVD_BIT]                  = 1'b0;
    ctrl_first_rd[DEB_LSB +: DEB_W]          = debounce_select;
    ctrl_first_rd[EN_BIT]                    = module_enable;
    ctrl_first_rd[ICF_BIT]                   = spi_incomplete_flag;
    ctrl_second_rd                           = '0;
    ctrl_second_rd[TXDIR_BIT]                = transmit_direction_ctl;
    ctrl_second_rd[TXACK_BIT]                = transmit_ack_ctl;
  end

  // Read selection; unmapped addresses and the clear register read as zero.
  assign rd_mux = (reg_addr_in == ADDR_CTRL_FIRST)  ? ctrl_first_rd :
                  (reg_addr_in == ADDR_CTRL_SECOND) ? ctrl_second_rd :
                  (reg_addr_in == ADDR_FLAGS)       ? DATA_W'(flags) :
                  (reg_addr_in == ADDR_INT_STAT)    ? DATA_W'(int_stat) :
                  (reg_addr_in == ADDR_INT_EN)      ? DATA_W'(int_en) : RDATA_IDLE;

  // Pin inputs come from outside the clock domain and are synchronised first.
  smed_sync2 #(
    .W (3)
  ) u_pin_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .rst_val_in  ({1'b0, LINE_IDLE, LINE_IDLE}),
    .d_in        ({hw_option_enable_in, scl_pin_in, sda_pin_in}),
    .q_out       ({option_sync, scl_sync, sda_sync})
  );

  // The bus clock filter runs only while the two-wire function is live.
  smed_debounce u_scl_deb (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .run_in      (i2c_run),
    .sel_in      (debounce_select),
    .d_in        (scl_sync),
    .q_out       (scl_deb)
  );

  // Control register: nothing here is touched by an enable rise, so SPI and
  // two-wire settings survive it and must be set up by software beforehand.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      operating_mode_select <= MODE_RST;
      debounce_select       <= DEB_RST;
      module_enable         <= EN_RST;
      spi_incomplete_flag   <= ICF_RST;
    end else if (ce_in) begin
      if (wr_ctrl_first) begin
        operating_mode_select <= reg_wdata_in[MODE_LSB +: MODE_W];
        debounce_select       <= reg_wdata_in[DEB_LSB +: DEB_W];
        module_enable         <= reg_wdata_in[EN_BIT];
      end
      spi_incomplete_flag <= next_icf;
    end
  end

  // Direction and acknowledge controls hold their values across an enable rise.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      transmit_direction_ctl <= TXDIR_RST;
      transmit_ack_ctl       <= TXACK_RST;
    end else if (ce_in && wr_ctrl_second) begin
      transmit_direction_ctl <= reg_wdata_in[TXDIR_BIT];
      transmit_ack_ctl       <= reg_wdata_in[TXACK_BIT];
    end
  end

  // Enable history and status flags; the default lands on the edge after the rise.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      enable_prev <= 1'b0;
      flags       <= FLAGS_DEFAULT;
    end else if (ce_in) begin
      enable_prev <= enable_eff;
      flags       <= next_flags;
    end
  end

  // Interrupt status, enable and the level output.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      int_stat <= '0;
      int_en   <= '0;
      irq_out  <= 1'b0;
    end else if (ce_in) begin
      int_stat <= next_int_stat;
      if (wr_int_en) begin
        int_en <= smed_irq_t'(reg_wdata_in[IRQ_W-1:0]);
      end
      irq_out <= |(next_int_stat & int_en);
    end
  end

  // Read data stand for one cycle after each cycle of the read strobe.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= RDATA_IDLE;
    end else if (ce_in) begin
      reg_rdata_out <= reg_rd_in ? rd_mux : RDATA_IDLE;
    end
  end

  // Open-drain drivers: enables fall away whenever the two-wire function is off,
  // so a disabled module never loads the shared lines.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      scl_out    <= DRIVE_LEVL;
      sda_out    <= DRIVE_LEVL;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (ce_in) begin
      scl_out    <= DRIVE_LEVL;
      sda_out    <= DRIVE_LEVL;
      scl_oe_out <= i2c_run && scl_hold_low_in;
      sda_oe_out <= i2c_run && sda_drive_low_in;
    end
  end

  // Filtered bus view and its edges for the datapath; idle while disabled.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      scl_deb_prev     <= LINE_IDLE;
      scl_filtered_out <= LINE_IDLE;
      sda_sampled_out  <= LINE_IDLE;
      scl_rise_out     <= 1'b0;
      scl_fall_out     <= 1'b0;
    end else if (ce_in) begin
      scl_deb_prev     <= scl_deb;
      scl_filtered_out <= scl_deb;
      sda_sampled_out  <= i2c_run ? sda_sync : LINE_IDLE;
      scl_rise_out     <= i2c_run && scl_deb && !scl_deb_prev;
      scl_fall_out     <= i2c_run && !scl_deb && scl_deb_prev;
    end
  end

  // Status outputs for the datapaths, registered so they are glitch free.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      operating_mode_select_out  <= MODE_RST;
      i2c_active_out             <= 1'b0;
      spi_active_out             <= 1'b0;
      transmit_direction_ctl_out <= TXDIR_RST;
      transmit_ack_ctl_out       <= TXACK_RST;
      flags_out                  <= FLAGS_DEFAULT;
    end else if (ce_in) begin
      operating_mode_select_out  <= operating_mode_select;
      i2c_active_out             <= i2c_run;
      spi_active_out             <= spi_run;
      transmit_direction_ctl_out <= transmit_direction_ctl;
      transmit_ack_ctl_out       <= transmit_ack_ctl;
      flags_out                  <= next_flags;
    end
  end

endmodule : smed_ctrl

// File: bench/smed_ctrl_monitor.sv
// Concurrent checks on the ports of the serial module control block.
module smed_ctrl_monitor
  import smed_pkg::*;
(
  input wire logic                  core_clk_in,
  input wire logic                  rst_n_in,
  input wire logic                  ce_in,
  input wire logic [ADDR_W-1:0]     reg_addr_in,
  input wire logic                  reg_rd_in,
  input wire logic [DATA_W-1:0]     reg_rdata_out,
  input wire logic                  hw_option_enable_in,
  input wire logic                  scl_out,
  input wire logic                  sda_out,
  input wire logic                  scl_oe_out,
  input wire logic                  sda_oe_out,
  input wire logic                  scl_filtered_out,
  input wire logic                  sda_sampled_out,
  input wire logic                  scl_rise_out,
  input wire logic                  scl_fall_out,
  input wire logic [MODE_W-1:0]     operating_mode_select_out,
  input wire logic                  i2c_active_out,
  input wire logic                  spi_active_out,
  input wire smed_flags_t           flags_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // All checks share the system clock and its reset.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // The unused bit never reads back as one.
  property p_rsvd;
    reg_rd_in && ce_in && reg_addr_in == ADDR_CTRL_FIRST |=> !reg_rdata_out[RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
  // Outside two-wire run the pins are released and inputs held idle.
  property p_pins_off;
    !i2c_active_out [*2] |-> !scl_oe_out && !sda_oe_out;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pin driven while idle");
  property p_lines_idle;
    !i2c_active_out [*2] |-> scl_filtered_out && sda_sampled_out;
  endproperty
  a_lines_idle: assert property (p_lines_idle) else $error("line not idle");
  // Open-drain outputs only ever sink.
  property p_od;
    scl_out == DRIVE_LEVL && sda_out == DRIVE_LEVL;
  endproperty
  a_od: assert property (p_od) else $error("open-drain value not low");
  // Without the hardware option nothing becomes active.
  property p_option;
    (!hw_option_enable_in && ce_in) [*4] |-> !i2c_active_out && !spi_active_out;
  endproperty
  a_option: assert property (p_option) else $error("active without option");
  // Activity matches the mode field.
  property p_i2c_mode;
    i2c_active_out |-> operating_mode_select_out == SMED_MODE_I2C_SLAVE && !spi_active_out;
  endproperty
  a_i2c_mode: assert property (p_i2c_mode) else $error("two-wire run in wrong mode");
  property p_spi_mode;
    spi_active_out |-> operating_mode_select_out < 3'h6;
  endproperty
  a_spi_mode: assert property (p_spi_mode) else $error("spi run in wrong mode");
  // An enable rise in two-wire mode lands the flag defaults at once.
  property p_flags_dflt;
    $rose(i2c_active_out) && $past(operating_mode_select_out) == SMED_MODE_I2C_SLAVE
      |-> flags_out == FLAGS_DEFAULT;
  endproperty
  a_flags_dflt: assert property (p_flags_dflt) else $error("flags kept on enable");
  // Edge pulses coincide with the change of the filtered line.
  property p_rise;
    scl_rise_out |-> scl_filtered_out && !$past(scl_filtered_out);
  endproperty
  a_rise: assert property (p_rise) else $error("rise pulse without edge");
  property p_fall;
    scl_fall_out |-> !scl_filtered_out && $past(scl_filtered_out);
  endproperty
  a_fall: assert property (p_fall) else $error("fall pulse without edge");
endmodule : smed_ctrl_monitor

// File: bench/smed_i2c_partner.sv
// Two-wire bus master model owning the far end of the clock and data lines.
module smed_i2c_partner (
  input  wire logic core_clk_in,
  input  wire logic scl_oe_in,
  input  wire logic sda_oe_in,
  output logic      scl_line_out,
  output logic      sda_line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_low = 1'b0;

  // Pull-ups hold both lines high unless some party sinks them.
  assign scl_line_out = !(scl_low || scl_oe_in);
  assign sda_line_out = !sda_oe_in;

  // A low spike of n system clocks on the clock line.
  task automatic glitch(input int n);
    @(posedge core_clk_in);
    scl_low <= 1'b1;
    repeat (n) @(posedge core_clk_in);
    scl_low <= 1'b0;
  endtask : glitch

  // A frame of n clock periods at 64 ns; the line stands high between frames.
  task automatic frame(input int n);
    #7.2;
    repeat (n) begin
      scl_low = 1'b1;
      #32;
      scl_low = 1'b0;
      #32;
    end
  endtask : frame
endmodule : smed_i2c_partner

// File: bench/smed_ctrl_tb.sv
// Self-checking bench of the serial module control block.
module smed_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smed_pkg::*;
  logic              core_clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0, reg_rdata_out;
  logic              reg_wr_in = 1'b0, reg_rd_in = 1'b0, hw_option_enable_in = 1'b1;
  logic              scl_hold_low_in = 1'b0, sda_drive_low_in = 1'b0;
  logic              spi_incomplete_in = 1'b0, flags_load_in = 1'b0;
  smed_flags_t       flags_next_in = '0, flags_out;
  logic              scl_line, sda_line, scl_out, scl_oe_out, sda_out, sda_oe_out;
  logic              scl_filtered_out, sda_sampled_out, scl_rise_out, scl_fall_out;
  logic [MODE_W-1:0] operating_mode_select_out;
  logic              i2c_active_out, spi_active_out, irq_out;
  logic              transmit_direction_ctl_out, transmit_ack_ctl_out;
  int                miscompares = 0, cmp_count = 0, cyc = 0, fall_cnt = 0, rise_cnt = 0;

  smed_ctrl dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .hw_option_enable_in(hw_option_enable_in), .scl_pin_in(scl_line), .sda_pin_in(sda_line),
    .scl_hold_low_in(scl_hold_low_in), .sda_drive_low_in(sda_drive_low_in),
    .spi_incomplete_in(spi_incomplete_in), .flags_load_in(flags_load_in),
    .flags_next_in(flags_next_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_filtered_out(scl_filtered_out),
    .sda_sampled_out(sda_sampled_out), .scl_rise_out(scl_rise_out),
    .scl_fall_out(scl_fall_out), .operating_mode_select_out(operating_mode_select_out),
    .i2c_active_out(i2c_active_out), .spi_active_out(spi_active_out),
    .transmit_direction_ctl_out(transmit_direction_ctl_out),
    .transmit_ack_ctl_out(transmit_ack_ctl_out), .flags_out(flags_out), .irq_out(irq_out)
  );

  smed_i2c_partner partner (
    .core_clk_in(core_clk_in), .scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out),
    .scl_line_out(scl_line), .sda_line_out(sda_line)
  );

  // Clock, edge counters and a generous hang guard.
  always #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (scl_fall_out === 1'b1) fall_cnt <= fall_cnt + 1;
    if (scl_rise_out === 1'b1) rise_cnt <= rise_cnt + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Register port cycles; each returns just after the edge that ends its strobe.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 check(reg_rdata_out, exp);
  endtask : rd

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step

  task automatic icf_pulse;
    @(posedge core_clk_in);
    spi_incomplete_in <= 1'b1;
    @(posedge core_clk_in);
    spi_incomplete_in <= 1'b0;
  endtask : icf_pulse

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Register, debounce and link scenarios in turn.
  initial begin : main
    int n;
    int f0;
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(ADDR_CTRL_FIRST, 8'he0);
    wr(ADDR_CTRL_FIRST, 8'hff);
    rd(ADDR_CTRL_FIRST, 8'hef);
    check(8'(i2c_active_out | spi_active_out), 8'h00);
    rd(3'h7, 8'h00);
    wr(ADDR_CTRL_FIRST, 8'h00);
    wr(ADDR_CTRL_SECOND, 8'h03);
    wr(ADDR_CTRL_FIRST, 8'h02);
    step(2);
    check(8'(spi_active_out), 8'h01);
    rd(ADDR_CTRL_SECOND, 8'h03);
    wr(ADDR_INT_EN, 8'h0e);
    icf_pulse();
    rd(ADDR_CTRL_FIRST, 8'h03);
    rd(ADDR_INT_STAT, 8'h01);
    check(8'(irq_out), 8'h00);
    wr(ADDR_INT_EN, 8'h0f);
    step(1);
    check(8'(irq_out), 8'h01);
    wr(ADDR_INT_CLR, 8'h01);
    step(1);
    check(8'(irq_out), 8'h00);
    // Two-wire mode: pins stay released until enabled.
    wr(ADDR_CTRL_FIRST, 8'h00);
    wr(ADDR_CTRL_FIRST, 8'hc0);
    @(posedge core_clk_in) scl_hold_low_in <= 1'b1;
    step(3);
    check(8'(scl_oe_out), 8'h00);
    wr(ADDR_CTRL_FIRST, 8'hc2);
    step(2);
    check(8'(scl_oe_out), 8'h01);
    @(posedge core_clk_in) scl_hold_low_in <= 1'b0;
    sda_drive_low_in <= 1'b1;
    step(8);
    check(8'({sda_oe_out, sda_sampled_out}), 8'h02);
    @(posedge core_clk_in) sda_drive_low_in <= 1'b0;
    flags_load_in <= 1'b1;
    flags_next_in <= 5'h1f;
    @(posedge core_clk_in) flags_load_in <= 1'b0;
    #1 check(8'(flags_out), 8'h1f);
    wr(ADDR_CTRL_FIRST, 8'hc0);
    wr(ADDR_INT_CLR, 8'h0f);
    @(posedge core_clk_in) hw_option_enable_in <= 1'b0;
    step(4);
    wr(ADDR_CTRL_FIRST, 8'hc2);
    step(4);
    check(8'(i2c_active_out), 8'h00);
    @(posedge core_clk_in) hw_option_enable_in <= 1'b1;
    step(4);
    check(8'(i2c_active_out), 8'h01);
    check(8'(flags_out), 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_CTRL_SECOND, 8'h03);
    check(8'({transmit_ack_ctl_out, transmit_direction_ctl_out}), 8'h03);
    rd(ADDR_INT_STAT, 8'h08);
    icf_pulse();
    rd(ADDR_CTRL_FIRST, 8'hc2);
    // A spike one clock short of the filter length is dropped, one of full length passes.
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL_FIRST, {3'h6, 1'b0, 2'(c), 2'h2});
      n = (c == 0) ? 1 : (c == 1) ? int'(DEB_TWO_CYC) : int'(DEB_FOUR_CYC);
      for (int g = n - 1; g <= n; g++) begin
        f0 = fall_cnt;
        if (g > 0) partner.glitch(g);
        step(12);
        check(8'(fall_cnt - f0), 8'(g == n));
      end
    end
    f0 = rise_cnt;
    partner.frame(8);
    step(12);
    check(8'(rise_cnt - f0), 8'h08);
    wr(ADDR_CTRL_FIRST, 8'hcc);
    f0 = fall_cnt;
    partner.glitch(6);
    step(12);
    check(8'(fall_cnt - f0), 8'h00);
    check(8'(scl_filtered_out), 8'h01);
    @(posedge core_clk_in) ce_in <= 1'b0;
    wr(ADDR_CTRL_FIRST, 8'hc2);
    ce_in <= 1'b1;
    rd(ADDR_CTRL_FIRST, 8'hcc);
    test_done();
  end
endmodule : smed_ctrl_tb

bind smed_ctrl smed_ctrl_monitor u_mon (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .hw_option_enable_in(hw_option_enable_in), .scl_out(scl_out), .sda_out(sda_out),
  .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out), .scl_filtered_out(scl_filtered_out),
  .sda_sampled_out(sda_sampled_out), .scl_rise_out(scl_rise_out),
  .scl_fall_out(scl_fall_out), .operating_mode_select_out(operating_mode_select_out),
  .i2c_active_out(i2c_active_out), .spi_active_out(spi_active_out), .flags_out(flags_out)
);
